/* File: gpio_pkg.sv */
/*
 * constants for the three-port gpio block: register offsets, widths,
 * field positions and reset values.
 * assumes a byte-wide register port with offsets as printed.
 */
// Behaviour
// - direction bit 1 makes pin output; reset clears all direction registers
// - reset leaves output data latches unchanged
// - port a latch at 0x00, direction at 0x04
// - port b is 5 bits, latch at 0x01, direction at 0x05
// - port c is 6 bits, latch 0x02, direction 0x06, no pull-ups
// - port a pull-up enable register at 0x10, one bit per pin
// - port b pull-up enable register at 0x11, low five bits only
// - pull-up and direction select input, push-pull, pulled input, open-drain
// - port b direction bit 7 enables slow falling edge on port a 6,7
// - port b direction bit 6 enables slow falling edge on all port b pins
// - slow-edge enables never change direction, pull-up or drive mode
// - data read returns latch value for output bits
// - port a 0-3 feed main interrupt, bit 4 second interrupt, inputs only
// - port b bit 0 input feeds timer capture; held low when output
// - converter on and channel selected forces port b 3,4 input, no pull-up
// - converter on makes port c 4,5 references; selected 0-3 forced input
package gpio_pkg;
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] OFS_LATCH_A = 5'h00; // port a data
	localparam logic [ADDR_W-1:0] OFS_LATCH_B = 5'h01;
	localparam logic [ADDR_W-1:0] OFS_LATCH_C = 5'h02;
	localparam logic [ADDR_W-1:0] OFS_DIR_A   = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_DIR_B   = 5'h05;
	localparam logic [ADDR_W-1:0] OFS_DIR_C   = 5'h06;
	localparam logic [ADDR_W-1:0] OFS_PULL_A  = 5'h10;
	localparam logic [ADDR_W-1:0] OFS_PULL_B  = 5'h11;
	localparam int WIDTH_A = 8;
	localparam int WIDTH_B = 5;
	localparam int WIDTH_C = 6;
	localparam int SLOW_A_BIT = 7; // slow_edge_enable_a_hi in port b direction
	localparam int SLOW_B_BIT = 6; // slow_edge_enable_b_all
	localparam logic [7:0] DIR_RESET  = 8'h00;
	localparam logic [7:0] PULL_RESET = 8'h00;
	localparam logic [7:0] READ_ZERO  = 8'h00;
endpackage

/* File: gpio_three_port.sv */
/*
 * three-port general purpose i/o: data latches, direction, pull-up
 * enables, slow-edge enables and pin overrides for the converter,
 * interrupt and capture units.
 * assumes byte register port, pins synchronous to clock, pad resolves
 * pull-ups from the pull enables driven here.
 *
 * pin modes for ports a and b, from pull-up and direction bits:
 *   pull 0, dir 0: plain input
 *   pull 0, dir 1: push-pull output
 *   pull 1, dir 0: input with pull-up
 *   pull 1, dir 1: open-drain output with pull-up
 * port c has no pull-ups: dir 0 is input, dir 1 push-pull output.
 *
 * converter override order: a selected channel pin is an input with
 * no pull-up while the converter is on, whatever its stored bits say.
 * the stored direction and pull bits keep their values, so software
 * sees no change when it reads them back.
 *
 * every pad, interrupt and capture output is registered and lags its
 * cause by one clock; a register write shows at the pads two clocks
 * after the write strobe.
 */
// Strobed register access was decided locally.
`timescale 1ns/1ps
module gpio_three_port
	import gpio_pkg::*;
(
	input  wire logic                          clock,
	input  wire logic                          rst,
	input  wire logic [gpio_pkg::ADDR_W-1:0]   addr,
	input  wire logic [7:0]                    wrData,
	input  wire logic                          wrStb,
	input  wire logic                          rdStb,
	output logic      [7:0]                    rdData,
	input  wire logic [gpio_pkg::WIDTH_A-1:0]  padAIn,
	output logic      [gpio_pkg::WIDTH_A-1:0]  padAOut,
	output logic      [gpio_pkg::WIDTH_A-1:0]  padAOe,
	output logic      [gpio_pkg::WIDTH_A-1:0]  padAPullEn,
	input  wire logic [gpio_pkg::WIDTH_B-1:0]  padBIn,
	output logic      [gpio_pkg::WIDTH_B-1:0]  padBOut,
	output logic      [gpio_pkg::WIDTH_B-1:0]  padBOe,
	output logic      [gpio_pkg::WIDTH_B-1:0]  padBPullEn,
	input  wire logic [gpio_pkg::WIDTH_C-1:0]  padCIn,
	output logic      [gpio_pkg::WIDTH_C-1:0]  padCOut,
	output logic      [gpio_pkg::WIDTH_C-1:0]  padCOe,
	output logic                               slowEdgeEnableAHi,
	output logic                               slowEdgeEnableBAll,
	input  wire logic                          converterOn,
	input  wire logic [1:0]                    converterChanBSel,
	input  wire logic [3:0]                    converterChanCSel,
	output logic                               converterRefsActive,
	output logic      [3:0]                    mainIrqLines,
	output logic                               secondExternalInterrupt,
	output logic                               captureIn
);
	import gpio_pkg::*;

	logic [WIDTH_A-1:0] latchA_q;
	logic [WIDTH_B-1:0] latchB_q;
	logic [WIDTH_C-1:0] latchC_q;
	logic [WIDTH_A-1:0] dirA_q;
	logic [WIDTH_B-1:0] dirB_q;
	logic [WIDTH_C-1:0] dirC_q;
	logic [WIDTH_A-1:0] pullA_q;
	logic [WIDTH_B-1:0] pullB_q;
	logic               slowA_q;
	logic               slowB_q;
	logic [WIDTH_B-1:0] forceInB_d;
	logic [WIDTH_C-1:0] forceInC_d;
	logic [WIDTH_B-1:0] effDirB_d;
	logic [WIDTH_C-1:0] effDirC_d;
	logic [WIDTH_B-1:0] effPullB_d;
	logic [7:0]         driveB_d;
	logic [7:0]         rdData_d;

	// mixes latch and pin per bit: outputs show latch, inputs show pin
	function automatic logic [7:0] readMix(input logic [7:0] latch,
		input logic [7:0] dir, input logic [7:0] pin);
		readMix = (latch & dir) | (pin & ~dir);
	endfunction

	// open-drain drive: pull-up with output drives low only on a latched 0
	function automatic logic [7:0] driveEn(input logic [7:0] latch,
		input logic [7:0] dir, input logic [7:0] pull);
		driveEn = dir & ~(pull & latch);
	endfunction

	// data latches keep their contents through reset
	always_ff @(posedge clock)
	begin
		if (wrStb && addr == OFS_LATCH_A)
			latchA_q <= wrData[WIDTH_A-1:0];
		if (wrStb && addr == OFS_LATCH_B)
			latchB_q <= wrData[WIDTH_B-1:0];
		if (wrStb && addr == OFS_LATCH_C)
			latchC_q <= wrData[WIDTH_C-1:0];
	end

	// direction registers and slow-edge bits, cleared by reset
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			dirA_q  <= DIR_RESET[WIDTH_A-1:0];
			dirB_q  <= DIR_RESET[WIDTH_B-1:0];
			dirC_q  <= DIR_RESET[WIDTH_C-1:0];
			slowA_q <= 1'b0;
			slowB_q <= 1'b0;
		end
		else if (wrStb)
		begin
			if (addr == OFS_DIR_A)
				dirA_q <= wrData[WIDTH_A-1:0];
			if (addr == OFS_DIR_B)
			begin
				dirB_q  <= wrData[WIDTH_B-1:0];
				slowA_q <= wrData[SLOW_A_BIT];
				slowB_q <= wrData[SLOW_B_BIT];
			end
			if (addr == OFS_DIR_C)
				dirC_q <= wrData[WIDTH_C-1:0];
		end
	end

	// write-only pull-up enables
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			pullA_q <= PULL_RESET[WIDTH_A-1:0];
			pullB_q <= PULL_RESET[WIDTH_B-1:0];
		end
		else if (wrStb)
		begin
			if (addr == OFS_PULL_A)
				pullA_q <= wrData[WIDTH_A-1:0];
			if (addr == OFS_PULL_B)
				pullB_q <= wrData[WIDTH_B-1:0];
		end
	end

	// converter overrides; stored direction bits are untouched
	always_comb
	begin
		forceInB_d = {converterOn & converterChanBSel[1],
			converterOn & converterChanBSel[0], 3'b000};
		forceInC_d = {converterOn, converterOn,
			converterChanCSel & {4{converterOn}}};
		effDirB_d  = dirB_q & ~forceInB_d;
		effPullB_d = pullB_q & ~forceInB_d;
		effDirC_d  = dirC_q & ~forceInC_d;
		driveB_d   = driveEn({3'b000, latchB_q}, {3'b000, effDirB_d},
			{3'b000, effPullB_d});
	end

	// read mux; pull-up registers are write-only and read zero
	always_comb
	begin
		rdData_d = READ_ZERO;
		case (addr)
			OFS_LATCH_A: rdData_d = readMix(latchA_q, dirA_q, padAIn);
			OFS_LATCH_B: rdData_d = readMix({3'b000, latchB_q}, {3'b000, dirB_q},
				{3'b000, padBIn});
			OFS_LATCH_C: rdData_d = readMix({2'b00, latchC_q}, {2'b00, dirC_q},
				{2'b00, padCIn});
			OFS_DIR_A:   rdData_d = dirA_q;
			OFS_DIR_B:   rdData_d = {slowA_q, slowB_q, 1'b0, dirB_q};
			OFS_DIR_C:   rdData_d = {2'b00, dirC_q};
			default:     rdData_d = READ_ZERO;
		endcase
	end

	// read data stands in the cycle after the strobe only
	always_ff @(posedge clock)
	begin
		if (rst)
			rdData <= READ_ZERO;
		else if (rdStb)
			rdData <= rdData_d;
		else
			rdData <= READ_ZERO;
	end

	// port a pad drive; open-drain bits release the pad on a latched 1
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			padAOut    <= '0;
			padAOe     <= '0;
			padAPullEn <= '0;
		end
		else
		begin
			padAOut    <= latchA_q;
			padAOe     <= driveEn(latchA_q, dirA_q, pullA_q);
			padAPullEn <= pullA_q;
		end
	end

	// port b pad drive, after the converter override
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			padBOut    <= '0;
			padBOe     <= '0;
			padBPullEn <= '0;
		end
		else
		begin
			padBOut    <= latchB_q;
			padBOe     <= driveB_d[WIDTH_B-1:0];
			padBPullEn <= effPullB_d;
		end
	end

	// port c pad drive; no pull-ups on this port
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			padCOut <= '0;
			padCOe  <= '0;
		end
		else
		begin
			padCOut <= latchC_q;
			padCOe  <= effDirC_d;
		end
	end

	// slow-edge enables only steer the edge rate, never the pin mode
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			slowEdgeEnableAHi  <= 1'b0;
			slowEdgeEnableBAll <= 1'b0;
		end
		else
		begin
			slowEdgeEnableAHi  <= slowA_q;
			slowEdgeEnableBAll <= slowB_q;
		end
	end

	// converter reference pins follow the converter enable
	always_ff @(posedge clock)
	begin
		if (rst)
			converterRefsActive <= 1'b0;
		else
			converterRefsActive <= converterOn;
	end

	// main interrupt feed, gated off while pins are outputs
	always_ff @(posedge clock)
	begin
		if (rst)
			mainIrqLines <= 4'h0;
		else
			mainIrqLines <= padAIn[3:0] & ~dirA_q[3:0];
	end

	// second interrupt feed, gated off while the pin is an output
	always_ff @(posedge clock)
	begin
		if (rst)
			secondExternalInterrupt <= 1'b0;
		else
			secondExternalInterrupt <= padAIn[4] & ~dirA_q[4];
	end

	// capture feed is held low while its pin drives
	always_ff @(posedge clock)
	begin
		if (rst)
			captureIn <= 1'b0;
		else
			captureIn <= padBIn[0] & ~effDirB_d[0];
	end
endmodule

/* File: gpio_three_port_properties.sv */
/* checker for gpio_three_port pins, interrupts and reads; assumes one clock, sync reset */
`timescale 1ns/1ps
module gpio_three_port_properties (
	input wire logic	clock,
	input wire logic	rst,
	input wire logic	rdStb,
	input wire logic [7:0]	rdData,
	input wire logic [7:0]	padAIn,
	input wire logic [7:0]	padAOe,
	input wire logic [4:0]	padBIn,
	input wire logic [4:0]	padBOe,
	input wire logic [5:0]	padCOe,
	input wire logic	converterOn,
	input wire logic	converterRefsActive,
	input wire logic [3:0]	mainIrqLines,
	input wire logic	secondExternalInterrupt,
	input wire logic	captureIn
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// outputs follow their causes one clock later
	oe_reset_a: assert property ($fell(rst) |-> !padAOe && !padCOe) else $error("oe set");
	irq_mask_a: assert property (padAOe[4] |-> !secondExternalInterrupt) else $error("second_external_interrupt");
	irq_pins_a: assert property (!(mainIrqLines & ~$past(padAIn[3:0]))) else $error("irq");
	second_external_interrupt_pin_a: assert property (secondExternalInterrupt |-> $past(padAIn[4])) else $error("pin");
	cap_mask_a: assert property (padBOe[0] |-> !captureIn) else $error("capture");
	cap_pin_a: assert property (captureIn |-> $past(padBIn[0])) else $error("capture pin");
	refs_on_a: assert property ($past(converterOn) && !$past(rst) |-> converterRefsActive && !padCOe[5:4])
		else $error("refs");
	rd_idle_a: assert property (!$past(rdStb) |-> !rdData) else $error("rdData");
endmodule
bind gpio_three_port gpio_three_port_properties u_props (.*);

/* File: board_pins.sv */
/* board model: switches and pull-ups on one port; assumes enables high while the block drives */
`timescale 1ns/1ps
module board_pins #(parameter int W = 8) (
	input wire logic [W-1:0]	oe,
	input wire logic [W-1:0]	out,
	input wire logic [W-1:0]	pull,
	input wire logic [W-1:0]	swEn,
	input wire logic [W-1:0]	sw,
	output logic [W-1:0]		pin
);
	// block drive wins, then a closed switch, then the pull-up; a floating pin shows ~out
	assign pin = (oe & out) | (~oe & swEn & sw) | (~oe & ~swEn & (pull | ~out));
endmodule

/* File: three_port_gpio_with_pullups_tb_top.sv */
/* register-call tests for gpio_three_port; assumes board_pins on ports a and b */
`timescale 1ns/1ps
module three_port_gpio_with_pullups_tb_top;
	logic		clock = 1'h0, rst = 1'h1, wrStb = 1'h0, rdStb = 1'h0, converterOn = 1'h0;
	logic		slowEdgeEnableAHi, slowEdgeEnableBAll, converterRefsActive;
	logic		secondExternalInterrupt, captureIn;
	logic [1:0]	converterChanBSel = 2'h0;
	logic [3:0]	converterChanCSel = 4'h0, mainIrqLines;
	logic [4:0]	addr = 5'h00, padBIn, padBOut, padBOe, padBPullEn;
	logic [5:0]	padCIn = 6'h15, padCOut, padCOe;
	logic [7:0]	wrData = 8'h00, rdData, padAIn, padAOut, padAOe, padAPullEn;
	logic [7:0]	swA = 8'hd3;
	logic [4:0]	swB = 5'h01;
	int		n_errors = 0, cmp_count = 0;
	gpio_three_port u_dut (.*);
	// switches: port a all closed, set to 8'hd3; port b only bit 0 closed high
	board_pins #(.W(8)) u_padsA (.oe(padAOe), .out(padAOut), .pull(padAPullEn), .swEn(8'hff),
		.sw(swA), .pin(padAIn));
	board_pins #(.W(5)) u_padsB (.oe(padBOe), .out(padBOut), .pull(padBPullEn), .swEn(5'h01),
		.sw(swB), .pin(padBIn));
	initial forever #25 clock = ~clock;
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		n_errors += int'(got !== exp);
	endtask
	// one-cycle strobe; a read compares the byte standing in the next cycle
	task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wrData <= d;
		wrStb <= w;
		rdStb <= !w;
		@(posedge clock);
		wrStb <= 1'h0;
		rdStb <= 1'h0;
		if (!w) #1 chk(rdData, d);
	endtask
	task automatic end_sim;
		if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// pads settle two clocks after a write strobe
	initial
	begin
		repeat (4) @(posedge clock);
		rst <= 1'h0;
		acc(1, 5'h00, 8'h5a);
		acc(1, 5'h04, 8'h0f);
		acc(1, 5'h10, 8'h03);
		#101;
		chk(padAOe, 8'h0d);
		chk({padAPullEn[3:0], mainIrqLines}, 8'h30);
		acc(0, 5'h00, 8'hda);
		acc(0, 5'h10, 8'h00);
		acc(0, 5'h1f, 8'h00);
		acc(1, 5'h01, 8'h07);
		acc(1, 5'h05, 8'hc1);
		#101;
		chk({slowEdgeEnableAHi, slowEdgeEnableBAll, captureIn, padBOe}, 8'hc1);
		chk(padAOe, 8'h0d);
		acc(0, 5'h05, 8'hc1);
		acc(0, 5'h01, 8'h19);
		acc(1, 5'h05, 8'h18);
		acc(1, 5'h11, 8'h18);
		acc(1, 5'h06, 8'hff);
		acc(1, 5'h02, 8'hff);
		#101;
		chk({padBPullEn, captureIn, padBOe[4:3]}, 8'hc7);
		@(posedge clock);
		converterOn <= 1'h1;
		converterChanBSel <= 2'h3;
		converterChanCSel <= 4'h1;
		#101;
		chk({padBOe[4:3], padCOe}, 8'h0e);
		chk({padBPullEn, converterRefsActive, 2'h0}, 8'h04);
		acc(0, 5'h02, 8'h3f);
		acc(0, 5'h05, 8'h18);
		@(posedge clock);
		rst <= 1'h1;
		converterOn <= 1'h0;
		@(posedge clock);
		rst <= 1'h0;
		#101;
		chk(padAOut, 8'h5a);
		chk({padAOe[3:0], mainIrqLines}, 8'h03);
		chk({padCOut, padBOut[1:0]}, 8'hff);
		acc(0, 5'h02, 8'h15);
		@(posedge clock);
		swA <= 8'h1c;
		#101;
		chk({3'h0, secondExternalInterrupt, mainIrqLines}, 8'h1c);
		end_sim();
	end
endmodule
